// >>> hdl/jtxlc_pattern_mem.sv
`include "jtxlc_defines.svh"

module jtxlc_pattern_mem (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic [1:0]  rd_idx,
    output logic      [15:0] rd_data
);

    jtxlc_pkg::jtxlc_mem_state_t st_q;
    jtxlc_pkg::jtxlc_mem_state_t st_d;

    always_comb begin
        st_d = st_q;
        if (wr_en) begin
            if (wr_addr[0]) begin
                st_d.words[wr_addr[2:1]][15:8] = wr_data;
            end else begin
                st_d.words[wr_addr[2:1]][7:0] = wr_data;
            end
        end
        st_d.rd = st_q.words[rd_idx];
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= '0;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign rd_data = st_q.rd;

endmodule

// >>> hdl/jtxlc_top.sv
// The strobed register port was decided locally.
`include "jtxlc_defines.svh"

// Summary of operation
// RL1: Sync mode picks separate, global, forced or ignored sync request.
// RL2: Polarity bit set makes the sync request input active high.
// RL3: Polarity clear: sync request low asks for code group sync.
// RL4: Bypass skips encoding; symbol top two bits forced to zero.
// RL5: Invert bit inverts all ten bits of each output symbol.
// RL6: Mirror bit reverses bit order of each ten-bit symbol.
// RL7: Checksum disable zeroes the checksum parameter output but not the 0x78 readback, test use only.
// RL8: Injection select: 16-bit words at sample input, or symbols.
// RL9: Test mode field selects normal, checker, toggle, PN, ramp data.
// RL10: Mode 101 repeats user patterns one to four continuously.
// RL11: Mode 110 sends user patterns one to four once, then zeros.
// RL12: Repeat count gives extra alignment sequence passes beyond one.
// RL13: Alignment sequence only sent when alignment mode is enabled code.
// RL14: Writable device, bank and lane identifiers reported as parameters.
// RL15: Scrambler bit enables scrambling and reports parameter as one.
// RL16: Lane control bit zero selects one lane; one is reserved.
// RL17: Octets per frame read back as twice converters over lanes.
// RL18: Five-bit frames per multiframe field drives multiframe length.
// RL19: Converter count bit zero means primary input only feeds link.
// RL20: Control bits field: none, overrange, or overflow and underflow.
// RL21: Resolution parameter reads back as thirteen.
// RL22: Total bits per sample reads back as fifteen.
// RL23: Samples per frame, density flag and control words read zero.
// RL24: Lane checksum is sum of parameters modulo 256, read only.

module jtxlc_top (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        sync_request_in,
    input  wire logic [1:0]  ilas_mode_in,
    input  wire logic [13:0] adc_sample,
    input  wire logic        overrange_in,
    input  wire logic        overflow_in,
    input  wire logic        underflow_in,
    input  wire logic [7:0]  raw_octet_in,
    input  wire logic [9:0]  enc_symbol_in,
    output logic      [15:0] tx_word,
    output logic      [9:0]  tx_symbol,
    output logic             sync_active,
    output logic             sync_input_cmos,
    output logic             ilas_enable,
    output logic      [8:0]  ilas_passes,
    output logic      [4:0]  frames_per_mf,
    output logic             scramble_en,
    output logic      [7:0]  config_checksum_param,
    output logic             checksum_en
);

    // --------------------
    // Helpers
    // --------------------
    function automatic logic [9:0] jtxlc_mirror10(input logic [9:0] v);
        logic [9:0] r;
        r = '0;
        for (int i = 0; i < 10; i++) begin
            r[i] = v[9 - i];
        end
        return r;
    endfunction

    // F = (M * 2) / L with M and L stored as value minus one
    function automatic logic [7:0] jtxlc_octets(input logic m_bit,
                                               input logic l_bit);
        logic [7:0] m_val;
        logic [7:0] l_val;
        m_val = {7'h00, m_bit} + 8'h01;
        l_val = {7'h00, l_bit} + 8'h01;
        return 8'((m_val << 1) / l_val);
    endfunction

    // Sum of every lane parameter as sent, modulo 256
    function automatic logic [7:0] jtxlc_param_sum(
        input jtxlc_pkg::jtxlc_state_t s);
        logic [7:0] f_m1;
        f_m1 = jtxlc_octets(s.m, s.lane) - 8'h01;
        return s.device_identifier + {4'h0, s.bank_identifier} + {3'h0, s.lane_identifier} + {7'h00, s.scr}
             + {7'h00, s.lane} + f_m1 + {3'h0, s.k} + {7'h00, s.m}
             + {6'h00, s.cs} + {3'h0, `JTXLC_N_MINUS1}
             + {3'h0, `JTXLC_NP_MINUS1} + {3'h0, `JTXLC_S_MINUS1}
             + {7'h00, `JTXLC_HD_VALUE} + {3'h0, `JTXLC_CF_VALUE}
             + s.spare1 + s.spare2;
    endfunction

    // --------------------
    // State and pattern memory
    // --------------------
    jtxlc_pkg::jtxlc_state_t     st_q;
    jtxlc_pkg::jtxlc_state_t     st_d;
    logic                        pat_wr;
    logic [15:0]                 pat_word;
    jtxlc_pkg::jtxlc_sync_mode_t sync_mode;
    jtxlc_pkg::jtxlc_test_mode_t test_mode;
    jtxlc_pkg::jtxlc_inject_t    inject;

    assign pat_wr = reg_wr && (reg_addr[7:3] == `JTXLC_ADDR_USER_PAT_HI5);

    jtxlc_pattern_mem u_pattern_mem (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .wr_en   (pat_wr),
        .wr_addr (reg_addr[2:0]),
        .wr_data (reg_wdata),
        .rd_idx  (st_q.seq_idx),
        .rd_data (pat_word)
    );

    assign sync_mode = jtxlc_pkg::jtxlc_sync_mode_t'(
        st_q.ctrl2[`JTXLC_SYNC_MODE_LSB +: 2]);
    assign test_mode = jtxlc_pkg::jtxlc_test_mode_t'(
        st_q.ctrl3[`JTXLC_TMODE_LSB +: 3]);
    assign inject = jtxlc_pkg::jtxlc_inject_t'(
        st_q.ctrl3[`JTXLC_INJ_LSB +: 2]);

    // --------------------
    // Next state
    // --------------------
    always_comb begin
        logic        req;
        logic [15:0] gen;
        logic [15:0] sample;
        logic [9:0]  sym;
        logic        user_mode;
        req       = 1'b0;
        gen       = '0;
        sample    = '0;
        sym       = '0;
        user_mode = 1'b0;
        st_d      = st_q;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                `JTXLC_ADDR_LINK_CTRL2:
                    st_d.ctrl2 = reg_wdata & `JTXLC_CTRL2_WMASK;
                `JTXLC_ADDR_LINK_CTRL3: begin
                    st_d.ctrl3 = reg_wdata & `JTXLC_CTRL3_WMASK;
                    st_d.seq   = jtxlc_pkg::JTXLC_SEQ_IDLE;
                end
                `JTXLC_ADDR_ILAS_REPEAT: st_d.repeat_cnt = reg_wdata;
                `JTXLC_ADDR_DEVICE_ID:   st_d.device_identifier = reg_wdata; // [RL14]
                `JTXLC_ADDR_BANK_ID:     st_d.bank_identifier = reg_wdata[3:0];
                `JTXLC_ADDR_LANE_ID:     st_d.lane_identifier = reg_wdata[4:0];
                `JTXLC_ADDR_SCR_LANE: begin
                    st_d.scr  = reg_wdata[`JTXLC_SCR_BIT];
                    st_d.lane = reg_wdata[`JTXLC_LANE_BIT]; // [RL16]
                end
                `JTXLC_ADDR_FRAMES_MF:   st_d.k = reg_wdata[4:0]; // [RL18]
                `JTXLC_ADDR_CONV_COUNT:  st_d.m = reg_wdata[0]; // [RL19]
                `JTXLC_ADDR_RES_CTRL:
                    st_d.cs = reg_wdata[`JTXLC_CS_LSB +: 2];
                `JTXLC_ADDR_SPARE_ONE:   st_d.spare1 = reg_wdata;
                `JTXLC_ADDR_SPARE_TWO:   st_d.spare2 = reg_wdata;
                default: ;
            endcase
        end

        // Register reads; data stand only in the following cycle
        st_d.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                `JTXLC_ADDR_LINK_CTRL2:  st_d.rdata = st_q.ctrl2;
                `JTXLC_ADDR_LINK_CTRL3:  st_d.rdata = st_q.ctrl3;
                `JTXLC_ADDR_ILAS_REPEAT: st_d.rdata = st_q.repeat_cnt;
                `JTXLC_ADDR_DEVICE_ID:   st_d.rdata = st_q.device_identifier;
                `JTXLC_ADDR_BANK_ID:     st_d.rdata = {4'h0, st_q.bank_identifier};
                `JTXLC_ADDR_LANE_ID:     st_d.rdata = {3'h0, st_q.lane_identifier};
                `JTXLC_ADDR_SCR_LANE:
                    st_d.rdata = {st_q.scr, 6'h00, st_q.lane}; // [RL15]
                `JTXLC_ADDR_OCTETS_FRAME:
                    st_d.rdata = jtxlc_octets(st_q.m, st_q.lane); // [RL17]
                `JTXLC_ADDR_FRAMES_MF:   st_d.rdata = {3'h0, st_q.k};
                `JTXLC_ADDR_CONV_COUNT:  st_d.rdata = {7'h00, st_q.m};
                `JTXLC_ADDR_RES_CTRL:
                    st_d.rdata = {st_q.cs, 1'b0, `JTXLC_N_MINUS1}; // [RL21]
                `JTXLC_ADDR_TOTAL_BITS:
                    st_d.rdata = {3'h0, `JTXLC_NP_MINUS1}; // [RL22]
                `JTXLC_ADDR_SAMPLES_FRM:
                    st_d.rdata = {3'h0, `JTXLC_S_MINUS1}; // [RL23]
                `JTXLC_ADDR_DENSITY_CW:
                    st_d.rdata = {`JTXLC_HD_VALUE, 2'h0,
                                  `JTXLC_CF_VALUE}; // [RL23]
                `JTXLC_ADDR_SPARE_ONE:   st_d.rdata = st_q.spare1;
                `JTXLC_ADDR_SPARE_TWO:   st_d.rdata = st_q.spare2;
                `JTXLC_ADDR_LANE_CONFIG_CHECKSUM_PARAM:
                    st_d.rdata = jtxlc_param_sum(st_q); // [RL24]
                default: st_d.rdata = '0;
            endcase
        end

        // --------------------
        // Sync request handling
        // --------------------
        // Default sense is active low; polarity bit flips it
        req = st_q.ctrl2[`JTXLC_SYNC_POL_BIT] ? sync_request_in
                                              : !sync_request_in; // [RL2] [RL3]
        // One link only, so separate and global modes coincide here
        case (sync_mode)
            jtxlc_pkg::JTXLC_SYNC_SEPARATE: st_d.sync_active = req; // [RL1]
            jtxlc_pkg::JTXLC_SYNC_GLOBAL:   st_d.sync_active = req; // [RL1]
            jtxlc_pkg::JTXLC_SYNC_FORCE:    st_d.sync_active = 1'b1; // [RL1]
            jtxlc_pkg::JTXLC_SYNC_IGNORE:   st_d.sync_active = 1'b0; // [RL1]
            default:                        st_d.sync_active = 1'b0;
        endcase
        st_d.sync_cmos = st_q.ctrl2[`JTXLC_SYNC_CMOS_BIT];

        // --------------------
        // Test generators, free running so modes switch cleanly
        // --------------------
        st_d.phase    = !st_q.phase;
        st_d.pn_long  = {st_q.pn_long[21:0],
                         st_q.pn_long[22] ^ st_q.pn_long[17]};
        st_d.pn_short = {st_q.pn_short[7:0],
                         st_q.pn_short[8] ^ st_q.pn_short[4]};
        st_d.ramp     = st_q.ramp + 16'h0001;

        user_mode = (test_mode == jtxlc_pkg::JTXLC_TM_USR_REP) ||
                    (test_mode == jtxlc_pkg::JTXLC_TM_USR_ONE);
        case (st_q.seq)
            jtxlc_pkg::JTXLC_SEQ_IDLE: begin
                st_d.seq_idx = 2'h0;
                if (user_mode) begin
                    st_d.seq = jtxlc_pkg::JTXLC_SEQ_RUN;
                end
            end
            jtxlc_pkg::JTXLC_SEQ_RUN: begin
                st_d.seq_idx = st_q.seq_idx + 2'h1; // [RL10]
                if (!user_mode) begin
                    st_d.seq = jtxlc_pkg::JTXLC_SEQ_IDLE;
                end else if (test_mode == jtxlc_pkg::JTXLC_TM_USR_ONE &&
                             st_q.seq_idx == 2'h3) begin
                    st_d.seq = jtxlc_pkg::JTXLC_SEQ_DONE; // [RL11]
                end
            end
            jtxlc_pkg::JTXLC_SEQ_DONE: begin
                st_d.seq_idx = 2'h0;
                if (!user_mode) begin
                    st_d.seq = jtxlc_pkg::JTXLC_SEQ_IDLE;
                end
            end
            default: st_d.seq = jtxlc_pkg::JTXLC_SEQ_IDLE;
        endcase
        // Memory read lags the index by one cycle
        st_d.user_live = (st_q.seq == jtxlc_pkg::JTXLC_SEQ_RUN);

        case (test_mode)
            jtxlc_pkg::JTXLC_TM_NORMAL:  gen = '0;
            jtxlc_pkg::JTXLC_TM_CHECKER:
                gen = st_q.phase ? `JTXLC_CHECKER_B
                                 : `JTXLC_CHECKER_A; // [RL9]
            jtxlc_pkg::JTXLC_TM_TOGGLE:
                gen = {16{st_q.phase}}; // [RL9]
            jtxlc_pkg::JTXLC_TM_PN_LONG: gen = st_q.pn_long[15:0]; // [RL9]
            jtxlc_pkg::JTXLC_TM_PN_SHRT:
                gen = {st_q.pn_short[7:0], st_q.pn_short[8:1]}; // [RL9]
            jtxlc_pkg::JTXLC_TM_USR_REP,
            jtxlc_pkg::JTXLC_TM_USR_ONE:
                gen = st_q.user_live ? pat_word : 16'h0000; // [RL10] [RL11]
            jtxlc_pkg::JTXLC_TM_RAMP:    gen = st_q.ramp; // [RL9]
            default:                     gen = '0;
        endcase

        // --------------------
        // Sample word and symbol path
        // --------------------
        case (st_q.cs)
            2'h1:    sample = {adc_sample, overrange_in, 1'b0}; // [RL20]
            2'h2:    sample = {adc_sample, overflow_in,
                               underflow_in}; // [RL20]
            default: sample = {adc_sample, 2'h0}; // [RL20]
        endcase
        st_d.tx_word = (test_mode != jtxlc_pkg::JTXLC_TM_NORMAL &&
                        inject == jtxlc_pkg::JTXLC_INJ_SAMPLE)
                       ? gen : sample; // [RL8]

        sym = st_q.ctrl2[`JTXLC_BYPASS_BIT] ? {2'h0, raw_octet_in}
                                            : enc_symbol_in; // [RL4]
        if (test_mode != jtxlc_pkg::JTXLC_TM_NORMAL &&
            inject == jtxlc_pkg::JTXLC_INJ_SYMBOL) begin
            sym = gen[9:0]; // [RL8]
        end
        if (st_q.ctrl2[`JTXLC_INVERT_BIT]) begin
            sym = ~sym; // [RL5]
        end
        if (st_q.ctrl2[`JTXLC_MIRROR_BIT]) begin
            sym = jtxlc_mirror10(sym); // [RL6]
        end
        st_d.tx_symbol = sym;

        // --------------------
        // Link parameters towards the framer
        // --------------------
        st_d.ilas_enable = (ilas_mode_in == `JTXLC_ILAS_ON_CODE); // [RL13]
        st_d.ilas_passes = {1'b0, st_q.repeat_cnt} + 9'h001; // [RL12]
        st_d.frames_mf   = st_q.k; // [RL18]
        st_d.scramble_en = st_q.scr; // [RL15]
        st_d.chk_en      = !st_q.ctrl3[`JTXLC_CHK_DIS_BIT]; // [RL7]
        st_d.cfg_chk     = st_q.ctrl3[`JTXLC_CHK_DIS_BIT] ? 8'h00
                           : jtxlc_param_sum(st_q); // [RL7] [RL24]
    end

    // --------------------
    // State register
    // --------------------
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q          <= '0;
            st_q.k        <= `JTXLC_RST_K;
            st_q.cs       <= `JTXLC_RST_CS;
            st_q.pn_long  <= `JTXLC_PN_LONG_SEED;
            st_q.pn_short <= `JTXLC_PN_SHORT_SEED;
            st_q.seq      <= jtxlc_pkg::JTXLC_SEQ_IDLE;
        end else if (clk_en) begin
            st_q <= st_d;
        end
    end

    assign reg_rdata             = st_q.rdata;
    assign tx_word               = st_q.tx_word;
    assign tx_symbol             = st_q.tx_symbol;
    assign sync_active           = st_q.sync_active;
    assign sync_input_cmos       = st_q.sync_cmos;
    assign ilas_enable           = st_q.ilas_enable;
    assign ilas_passes           = st_q.ilas_passes;
    assign frames_per_mf         = st_q.frames_mf;
    assign scramble_en           = st_q.scramble_en;
    assign config_checksum_param = st_q.cfg_chk;
    assign checksum_en           = st_q.chk_en;

endmodule

// >>> shared/jtxlc_defines.svh
`ifndef JTXLC_DEFINES_SVH
`define JTXLC_DEFINES_SVH

// --------------------
// Register byte addresses
// --------------------
`define JTXLC_ADDR_LINK_CTRL2    8'h61
`define JTXLC_ADDR_LINK_CTRL3    8'h62
`define JTXLC_ADDR_ILAS_REPEAT   8'h63
`define JTXLC_ADDR_DEVICE_ID     8'h64
`define JTXLC_ADDR_BANK_ID       8'h65
`define JTXLC_ADDR_LANE_ID       8'h66
`define JTXLC_ADDR_SCR_LANE      8'h6e
`define JTXLC_ADDR_OCTETS_FRAME  8'h6f
`define JTXLC_ADDR_FRAMES_MF     8'h70
`define JTXLC_ADDR_CONV_COUNT    8'h71
`define JTXLC_ADDR_RES_CTRL      8'h72
`define JTXLC_ADDR_TOTAL_BITS    8'h73
`define JTXLC_ADDR_SAMPLES_FRM   8'h74
`define JTXLC_ADDR_DENSITY_CW    8'h75
`define JTXLC_ADDR_SPARE_ONE     8'h76
`define JTXLC_ADDR_SPARE_TWO     8'h77
`define JTXLC_ADDR_LANE_CONFIG_CHECKSUM_PARAM   8'h78
// User patterns: 0x80..0x87, even = low byte, odd = high byte
`define JTXLC_ADDR_USER_PAT_HI5  5'h10

// --------------------
// Field positions and writable masks
// --------------------
`define JTXLC_SYNC_MODE_LSB      6
`define JTXLC_SYNC_POL_BIT       5
`define JTXLC_SYNC_CMOS_BIT      4
`define JTXLC_BYPASS_BIT         2
`define JTXLC_INVERT_BIT         1
`define JTXLC_MIRROR_BIT         0
`define JTXLC_CHK_DIS_BIT        7
`define JTXLC_INJ_LSB            4
`define JTXLC_TMODE_LSB          0
`define JTXLC_SCR_BIT            7
`define JTXLC_LANE_BIT           0
`define JTXLC_CS_LSB             6
`define JTXLC_CTRL2_WMASK        8'hf7
`define JTXLC_CTRL3_WMASK        8'hb7
`define JTXLC_ILAS_ON_CODE       2'h1

// --------------------
// Fixed link parameters (N, NP and S as value minus one), reset values and checker patterns
// --------------------
`define JTXLC_N_MINUS1           5'h0d
`define JTXLC_NP_MINUS1          5'h0f
`define JTXLC_S_MINUS1           5'h00
`define JTXLC_CF_VALUE           5'h00
`define JTXLC_HD_VALUE           1'h0
`define JTXLC_RST_K              5'h0f
`define JTXLC_RST_CS             2'h1
`define JTXLC_PN_LONG_SEED       23'h7fffff
`define JTXLC_PN_SHORT_SEED      9'h1ff
`define JTXLC_CHECKER_A          16'haaaa
`define JTXLC_CHECKER_B          16'h5555

`endif

// >>> shared/jtxlc_pkg.sv
package jtxlc_pkg;

    typedef enum logic [1:0] {
        JTXLC_SYNC_SEPARATE = 2'h0,
        JTXLC_SYNC_GLOBAL   = 2'h1,
        JTXLC_SYNC_FORCE    = 2'h2,
        JTXLC_SYNC_IGNORE   = 2'h3
    } jtxlc_sync_mode_t;

    typedef enum logic [2:0] {
        JTXLC_TM_NORMAL  = 3'h0,
        JTXLC_TM_CHECKER = 3'h1,
        JTXLC_TM_TOGGLE  = 3'h2,
        JTXLC_TM_PN_LONG = 3'h3,
        JTXLC_TM_PN_SHRT = 3'h4,
        JTXLC_TM_USR_REP = 3'h5,
        JTXLC_TM_USR_ONE = 3'h6,
        JTXLC_TM_RAMP    = 3'h7
    } jtxlc_test_mode_t;

    typedef enum logic [1:0] {
        JTXLC_INJ_SAMPLE = 2'h0,
        JTXLC_INJ_SYMBOL = 2'h1,
        JTXLC_INJ_RSV2   = 2'h2,
        JTXLC_INJ_RSV3   = 2'h3
    } jtxlc_inject_t;

    typedef enum logic [2:0] {
        JTXLC_SEQ_IDLE = 3'b001,
        JTXLC_SEQ_RUN  = 3'b010,
        JTXLC_SEQ_DONE = 3'b100
    } jtxlc_seq_t;

    typedef struct packed {
        logic [3:0][15:0] words;
        logic [15:0]      rd;
    } jtxlc_mem_state_t;

    typedef struct packed {
        logic [7:0]  ctrl2;
        logic [7:0]  ctrl3;
        logic [7:0]  repeat_cnt;
        logic [7:0]  device_identifier;
        logic [3:0]  bank_identifier;
        logic [4:0]  lane_identifier;
        logic        scr;
        logic        lane;
        logic [4:0]  k;
        logic        m;
        logic [1:0]  cs;
        logic [7:0]  spare1;
        logic [7:0]  spare2;
        logic [7:0]  rdata;
        logic        phase;
        logic [22:0] pn_long;
        logic [8:0]  pn_short;
        logic [15:0] ramp;
        jtxlc_seq_t  seq;
        logic [1:0]  seq_idx;
        logic        user_live;
        logic [15:0] tx_word;
        logic [9:0]  tx_symbol;
        logic        sync_active;
        logic        ilas_enable;
        logic [8:0]  ilas_passes;
        logic [4:0]  frames_mf;
        logic        scramble_en;
        logic        sync_cmos;
        logic [7:0]  cfg_chk;
        logic        chk_en;
    } jtxlc_state_t;

endpackage

// >>> verif/jesd_tx_link_control_tb.sv
module jesd_tx_link_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, want = 1'b0, pol = 1'b0;
    logic        overrange_in = 1'b1, overflow_in = 1'b0;
    logic        underflow_in = 1'b1, sync_request_in, sync_active;
    logic        sync_input_cmos, ilas_enable, scramble_en, checksum_en;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [7:0]  raw_octet_in = 8'h00, config_checksum_param;
    logic [1:0]  ilas_mode_in = 2'h0;
    logic [13:0] adc_sample = 14'h0000;
    logic [9:0]  enc_symbol_in = 10'h000, tx_symbol;
    logic [15:0] tx_word;
    logic [8:0]  ilas_passes;
    logic [4:0]  frames_per_mf;
    int          num_errors = 0, checks_done = 0, cyc = 0;
    logic [15:0] rt [18] = '{16'h6100, 16'h6200, 16'h6300, 16'h6400, 16'h6500,
        16'h6600, 16'h6e00, 16'h6f02, 16'h700f, 16'h7100, 16'h724d,
        16'h730f, 16'h7400, 16'h7500, 16'h7600, 16'h7700, 16'h782d, 16'h5000};
    logic [15:0] wt [12] = '{16'h64a5, 16'h650c, 16'h6613, 16'h6e80, 16'h701f,
        16'h7280, 16'h763c, 16'h77c3, 16'h6fff, 16'h73ff, 16'h78ff, 16'h74ff};
    logic [15:0] bt [12] = '{16'h64a5, 16'h650c, 16'h6613, 16'h6e80, 16'h6f02,
        16'h701f, 16'h728d, 16'h730f, 16'h7400, 16'h763c, 16'h77c3, 16'h7802};
    logic [7:0]  mt [7] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h11, 8'h21};
    logic [7:0]  it [3] = '{8'h00, 8'h01, 8'hff};
    logic [1:0]  cs_exp [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
    jtxlc_top DUT (.*);
    jtxlc_rx_model u_rx (.mclk, .sys_rst, .want_sync(want), .pol_high(pol),
        .sync_request_in);
    always #5 mclk = ~mclk;
    task automatic finish_test();
        if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= w;
        reg_rd    <= !w;
        reg_addr  <= a;
        reg_wdata <= d;
        wait_n(1);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(16'(reg_rdata), 16'(e));
    endtask
    // ------------------------------
    // Free-running sample stimulus
    // ------------------------------
    always @(posedge mclk) begin
        cyc           <= cyc + 1;
        adc_sample    <= adc_sample + 14'h0001;
        raw_octet_in  <= raw_octet_in + 8'h03;
        enc_symbol_in <= enc_symbol_in + 10'h007;
        ilas_mode_in  <= adc_sample[1:0];
        want          <= adc_sample[3];
        if (cyc == 2000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        foreach (rt[i]) rd(rt[i][15:8], rt[i][7:0]);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, 8'h72, 8'(c << 6));
            wait_n(1);
            chk(16'(tx_word[1:0]), 16'(cs_exp[c]));
        end
        foreach (wt[i]) bus(1'b1, wt[i][15:8], wt[i][7:0]);
        foreach (bt[i]) rd(bt[i][15:8], bt[i][7:0]);
        chk(16'(config_checksum_param), 16'h0002);
        chk({frames_per_mf, 10'h0, scramble_en}, 16'hf801);
        foreach (it[i]) begin
            bus(1'b1, 8'h63, it[i]);
            wait_n(1);
            chk(16'(ilas_passes), 16'(it[i]) + 16'h0001);
        end
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 8'h61, {i[2:0], i[0], 1'b0, i[2:0]});
            pol <= i[0];
            wait_n(16);
            if (i > 3) chk(16'({sync_input_cmos, sync_active}),
                16'({i[0], !i[1]}));
        end
        foreach (mt[i]) begin
            bus(1'b1, 8'h62, mt[i]);
            wait_n(12);
        end
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, 8'(8'h80 + 2 * k), 8'(k + 1));
            bus(1'b1, 8'(8'h81 + 2 * k), 8'(16 * k + 16));
        end
        for (int m = 5; m < 7; m++) begin
            bus(1'b1, 8'h62, 8'(m));
            wait_n(3);
            for (int j = 0; j < 12; j++) begin
                chk(tx_word, (m == 6 && j > 3) ? 16'h0 :
                    {8'(16 * (j % 4) + 16), 8'(j % 4 + 1)});
                wait_n(1);
            end
        end
        bus(1'b1, 8'h62, 8'h80);
        wait_n(1);
        chk({config_checksum_param, 7'h0, checksum_en}, 16'h0000);
        rd(8'h78, 8'h02);
        finish_test();
    end
endmodule

// >>> verif/jtxlc_props.sv
module jtxlc_props (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        sync_request_in,
    input wire logic [1:0]  ilas_mode_in,
    input wire logic [13:0] adc_sample,
    input wire logic [7:0]  raw_octet_in,
    input wire logic [9:0]  enc_symbol_in,
    input wire logic [15:0] tx_word,
    input wire logic [9:0]  tx_symbol,
    input wire logic        sync_active,
    input wire logic        ilas_enable,
    input wire logic [7:0]  config_checksum_param
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------
    // Shadow of the control bytes
    // ----------------------------
    logic [7:0] c2_q;
    logic [7:0] c3_q;
    logic [3:0] age_q;
    logic [1:0] up_q;
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            c2_q  <= 8'h00;
            c3_q  <= 8'h00;
            age_q <= 4'h0;
            up_q  <= 2'h0;
        end else begin
            up_q  <= {up_q[0], 1'b1};
            // Any ctrl3 write restarts the user pattern sequence, except in mode 110 at seq_idx 3, so age restarts
            age_q <= (reg_wr && reg_addr == 8'h62) ? 4'h0 :
                     age_q + {3'h0, age_q != 4'hf};
            if (reg_wr && reg_addr == 8'h61) c2_q <= reg_wdata;
            if (reg_wr && reg_addr == 8'h62) c3_q <= reg_wdata;
        end
    end
    function automatic logic [9:0] exp_sym(input logic [7:0] c,
        input logic [7:0] raw, input logic [9:0] enc);
        logic [9:0] b;
        logic [9:0] r;
        b = c[2] ? {2'h0, raw} : enc;
        b = c[1] ? ~b : b;
        for (int i = 0; i < 10; i++) r[i] = b[9 - i];
        return c[0] ? r : b;
    endfunction
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    chk_ilas_gate: assert property (
        up_q[1] |-> ilas_enable == ($past(ilas_mode_in) == 2'h1))
        else $error("ilas enable wrong");
    chk_sync_sense: assert property (
        up_q[1] && !$past(c2_q[7]) |-> sync_active ==
        ($past(sync_request_in) == $past(c2_q[5])))
        else $error("sync sense wrong");
    chk_symbol_ops: assert property (
        up_q[1] && !($past(c3_q[5:4]) == 2'h1 && $past(c3_q[2:0]) != 3'h0)
        |-> tx_symbol == exp_sym($past(c2_q), $past(raw_octet_in),
        $past(enc_symbol_in)))
        else $error("symbol path wrong");
    chk_word_normal: assert property (
        up_q[1] && ($past(c3_q[5:4]) != 2'h0 || $past(c3_q[2:0]) == 3'h0)
        |-> tx_word[15:2] == $past(adc_sample))
        else $error("sample word wrong");
    chk_chk_off: assert property (
        c3_q[7] && age_q > 4'h1 |-> config_checksum_param == 8'h00)
        else $error("checksum not suppressed");
    chk_alt_pattern: assert property (
        age_q > 4'h2 && c3_q inside {8'h01, 8'h02}
        |-> tx_word == ~$past(tx_word))
        else $error("alternating pattern wrong");
    chk_ramp_step: assert property (
        age_q > 4'h2 && c3_q == 8'h07 |-> tx_word == $past(tx_word) + 16'h1)
        else $error("ramp step wrong");
    chk_user_loop: assert property (
        age_q > 4'h7 && c3_q == 8'h05 |-> tx_word == $past(tx_word, 4))
        else $error("user pattern loop wrong");
    cover property (age_q > 4'h7 && c3_q == 8'h05);
    cover property (c2_q[1:0] == 2'h3 && c2_q[2]);
    cover property (c3_q == 8'h11 && age_q > 4'h2);
endmodule
bind jtxlc_top jtxlc_props u_props (.*);

// >>> verif/jtxlc_rx_model.sv
module jtxlc_rx_model (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic want_sync,
    input  wire logic pol_high,
    output logic      sync_request_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Receiver keeps asking for sync while held in reset
    logic req_q = 1'b1;
    always @(posedge mclk) req_q <= sys_rst | want_sync;
    assign sync_request_in = !(req_q ^ pol_high);
endmodule
